// ==== tmr1c_defines.svh ====
// tmr1c_defines.svh: offsets, field positions, reset values and timing counts for the timer
// assumes it is included by bare name from every file that needs it
`ifndef TMR1C_DEFINES_SVH
`define TMR1C_DEFINES_SVH

// ****************************************************************
// register word addresses (byte offsets, one aligned word each)
// ****************************************************************
`define TMR1C_OFS_CTRL      6'h00
`define TMR1C_OFS_COUNT     6'h04
`define TMR1C_OFS_STATUS    6'h08
`define TMR1C_OFS_MASK      6'h0c
`define TMR1C_OFS_GATE      6'h10

// ****************************************************************
// control register fields
// ****************************************************************
`define TMR1C_CS_HI         7
`define TMR1C_CS_LO         6
`define TMR1C_PS_HI         5
`define TMR1C_PS_LO         4
`define TMR1C_OSCEN_BIT     3
`define TMR1C_SYNC_BIT      2
`define TMR1C_RUN_BIT       0
`define TMR1C_CTRL_WMASK    8'hfd
`define TMR1C_CTRL_RESET    8'h00

// ****************************************************************
// status / mask fields
// ****************************************************************
`define TMR1C_ST_GATE_BIT   0
`define TMR1C_ST_OVF_BIT    1
`define TMR1C_ST_RESET      2'h0

// ****************************************************************
// timing
// ****************************************************************
`define TMR1C_INSTR_DIV     4

`endif

// ==== tmr1c_edge_sync.sv ====
// tmr1c_edge_sync.sv: two-flop synchroniser with rising edge pulse
// assumes one clock; raw input may be asynchronous
`timescale 1ns/1ps
`include "tmr1c_defines.svh"
module tmr1c_edge_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic bypass,
  input  wire logic raw_in,
  output logic      rise_pulse
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  logic sel_lvl;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
      last_r <= sel_lvl;
    end
  end

  // bypass takes the raw level, two flops shorter latency, no metastability guard
  always_comb begin
    sel_lvl    = bypass ? raw_in : sync_r;
    rise_pulse = sel_lvl & ~last_r;
  end
endmodule

// ==== tmr1c_pkg.sv ====
// tmr1c_pkg.sv: types shared by the timer control files
// assumes tmr1c_defines.svh holds the numbers
package tmr1c_pkg;

  typedef enum logic [1:0] {
    TMR1C_SRC_INSTR = 2'b00,
    TMR1C_SRC_SYS   = 2'b01,
    TMR1C_SRC_EXT   = 2'b10,
    TMR1C_SRC_CAP   = 2'b11
  } tmr1c_src_t;

  typedef enum logic [1:0] {
    TMR1C_BUS_IDLE = 2'b00,
    TMR1C_BUS_ACK  = 2'b01
  } tmr1c_bus_t;

endpackage

// ==== tmr1c_prescaler.sv ====
// tmr1c_prescaler.sv: divides a tick stream by 1, 2, 4 or 8
// assumes ticks are one-cycle pulses of the system clock
`timescale 1ns/1ps
`include "tmr1c_defines.svh"
module tmr1c_prescaler #(
  parameter int WIDTH = 3
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clear,
  input  wire logic [1:0] ratio_sel,
  input  wire logic       tick_in,
  output logic            tick_out
);
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic [WIDTH-1:0] top;

  // refused at elaboration: a 1:8 ratio needs a count of seven
  if (WIDTH < 3) begin : g_bad_width
    $error("prescaler needs at least three bits");
  end

  always_comb begin
    top      = WIDTH'((1 << ratio_sel) - 1);
    tick_out = tick_in && (cnt_r >= top);
    cnt_nxt  = cnt_r;
    if (clear) begin
      cnt_nxt = '0;
    end else if (tick_in) begin
      cnt_nxt = (cnt_r >= top) ? '0 : WIDTH'(cnt_r + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  ratio_a: assert property (@(posedge clk) disable iff (!reset_n)
    tick_out |-> tick_in && cnt_r == top)
    else $error("prescaler tick at wrong count");
endmodule

// ==== tmr1c_timer.sv ====
// tmr1c_timer.sv: timer clock source, prescale, run and gate-event control with wishbone regs
// assumes classic wishbone slave on clk; ext/crystal/cap inputs are slow levels
//
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "tmr1c_defines.svh"
module tmr1c_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_clock_pin,
  input  wire logic        crystal_pins,
  input  wire logic        cap_sense_osc,
  input  wire logic        gate_in,
  output logic             dedicated_osc_enable,
  output logic [CNT_W-1:0] count_value,
  output logic             irq
);

  // refused at elaboration: the count register is one bus word
  if (CNT_W < 8 || CNT_W > 32) begin : g_bad_width
    $error("counter width must be 8 to 32");
  end

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0]       ctrl_r;
  logic [7:0]       ctrl_nxt;
  logic [1:0]       status_r;
  logic [1:0]       status_nxt;
  logic [1:0]       mask_r;
  logic [1:0]       mask_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             gate_ff_r;
  logic             gate_ff_nxt;
  logic             gate_last_r;
  logic [1:0]       div_r;
  logic [1:0]       div_nxt;
  logic [31:0]      rdata_r;
  logic [31:0]      rdata_nxt;
  tmr1c_pkg::tmr1c_bus_t bus_r;
  tmr1c_pkg::tmr1c_bus_t bus_nxt;

  // ****************************************************************
  // control fields
  // ****************************************************************
  logic [1:0] clock_source_select;
  logic [1:0] input_prescale_select;
  logic       ext_clock_sync_ctrl;
  logic       counter_run;

  always_comb begin
    clock_source_select   = ctrl_r[`TMR1C_CS_HI:`TMR1C_CS_LO];
    input_prescale_select = ctrl_r[`TMR1C_PS_HI:`TMR1C_PS_LO];
    dedicated_osc_enable  = ctrl_r[`TMR1C_OSCEN_BIT];
    ext_clock_sync_ctrl   = ctrl_r[`TMR1C_SYNC_BIT];
    counter_run           = ctrl_r[`TMR1C_RUN_BIT];
    count_value           = cnt_r;
  end

  // ****************************************************************
  // clock source selection
  // ****************************************************************
  logic ext_raw;
  logic ext_tick;
  logic cap_tick;
  logic instr_tick;
  logic src_tick;
  logic ext_bypass;
  logic pre_tick;

  // sync bit only has meaning for external sources
  always_comb begin
    ext_raw    = dedicated_osc_enable ? crystal_pins : ext_clock_pin;
    ext_bypass = clock_source_select[1] & ext_clock_sync_ctrl;
  end

  tmr1c_edge_sync u_ext_sync (
    .clk        (clk),
    .reset_n    (reset_n),
    .bypass     (ext_bypass),
    .raw_in     (ext_raw),
    .rise_pulse (ext_tick)
  );

  // cap oscillator is always synchronised: it is free running and unrelated to clk
  tmr1c_edge_sync u_cap_sync (
    .clk        (clk),
    .reset_n    (reset_n),
    .bypass     (1'b0),
    .raw_in     (cap_sense_osc),
    .rise_pulse (cap_tick)
  );

  always_comb begin
    div_nxt    = 2'(div_r + 1'b1);
    instr_tick = (div_r == 2'(`TMR1C_INSTR_DIV - 1));
    case (tmr1c_pkg::tmr1c_src_t'(clock_source_select))
      tmr1c_pkg::TMR1C_SRC_CAP:   src_tick = cap_tick;
      tmr1c_pkg::TMR1C_SRC_EXT:   src_tick = ext_tick;
      tmr1c_pkg::TMR1C_SRC_SYS:   src_tick = 1'b1;
      tmr1c_pkg::TMR1C_SRC_INSTR: src_tick = instr_tick;
      default:                    src_tick = 1'b0;
    endcase
  end

  tmr1c_prescaler #(
    .WIDTH (3)
  ) u_pre (
    .clk       (clk),
    .reset_n   (reset_n),
    .clear     (~counter_run),
    .ratio_sel (input_prescale_select),
    .tick_in   (src_tick & counter_run),
    .tick_out  (pre_tick)
  );

  // ****************************************************************
  // counter, gate flip-flop, events
  // ****************************************************************
  logic       gate_fall;
  logic       ovf_evt;
  logic [1:0] evt;
  logic       bus_req;
  logic       wr_en;
  logic       rd_en;
  logic [31:0] wmask;

  always_comb begin
    bus_req   = wb_cyc_i & wb_stb_i & (bus_r == tmr1c_pkg::TMR1C_BUS_IDLE);
    wr_en     = bus_req & wb_we_i;
    rd_en     = bus_req & ~wb_we_i;
    wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    gate_fall = gate_last_r & ~gate_in;
    ovf_evt   = counter_run & pre_tick & (&cnt_r);
    evt       = 2'h0;
    evt[`TMR1C_ST_GATE_BIT] = gate_fall;
    evt[`TMR1C_ST_OVF_BIT]  = ovf_evt;

    cnt_nxt = cnt_r;
    if (wr_en && wb_adr_i == `TMR1C_OFS_COUNT) begin
      cnt_nxt = (cnt_r & ~wmask[CNT_W-1:0]) | (wb_dat_i[CNT_W-1:0] & wmask[CNT_W-1:0]);
    end else if (counter_run && pre_tick) begin
      cnt_nxt = CNT_W'(cnt_r + 1'b1);
    end

    gate_ff_nxt = gate_ff_r;
    if (!counter_run) begin
      gate_ff_nxt = 1'b0;
    end else if (gate_fall) begin
      gate_ff_nxt = ~gate_ff_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r       <= '0;
      gate_ff_r   <= 1'b0;
      gate_last_r <= 1'b0;
      div_r       <= 2'h0;
    end else begin
      cnt_r       <= cnt_nxt;
      gate_ff_r   <= gate_ff_nxt;
      gate_last_r <= gate_in;
      div_r       <= div_nxt;
    end
  end

  // ****************************************************************
  // wishbone slave and registers
  // ****************************************************************
  always_comb begin
    ctrl_nxt   = ctrl_r;
    mask_nxt   = mask_r;
    status_nxt = status_r;
    rdata_nxt  = rdata_r;
    bus_nxt    = tmr1c_pkg::TMR1C_BUS_IDLE;
    if (bus_req) begin
      bus_nxt = tmr1c_pkg::TMR1C_BUS_ACK;
    end
    if (wr_en && wb_sel_i[0]) begin
      case (wb_adr_i)
        `TMR1C_OFS_CTRL: ctrl_nxt = wb_dat_i[7:0] & `TMR1C_CTRL_WMASK;
        `TMR1C_OFS_MASK: mask_nxt = wb_dat_i[1:0];
        default:         ctrl_nxt = ctrl_r;
      endcase
    end
    if (rd_en) begin
      case (wb_adr_i)
        `TMR1C_OFS_CTRL:   rdata_nxt = {24'h0, ctrl_r};
        `TMR1C_OFS_COUNT:  rdata_nxt = 32'(cnt_r);
        `TMR1C_OFS_STATUS: rdata_nxt = {30'h0, status_r};
        `TMR1C_OFS_MASK:   rdata_nxt = {30'h0, mask_r};
        `TMR1C_OFS_GATE:   rdata_nxt = {30'h0, gate_ff_r, gate_in};
        default:           rdata_nxt = 32'h0;
      endcase
      // read of status clears it
      if (wb_adr_i == `TMR1C_OFS_STATUS) begin
        status_nxt = 2'h0;
      end
    end
    // set wins over the read clear in the same cycle
    status_nxt = status_nxt | evt;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r   <= `TMR1C_CTRL_RESET;
      mask_r   <= `TMR1C_ST_RESET;
      status_r <= `TMR1C_ST_RESET;
      rdata_r  <= 32'h0;
      bus_r    <= tmr1c_pkg::TMR1C_BUS_IDLE;
    end else begin
      ctrl_r   <= ctrl_nxt;
      mask_r   <= mask_nxt;
      status_r <= status_nxt;
      rdata_r  <= rdata_nxt;
      bus_r    <= bus_nxt;
    end
  end

  always_comb begin
    wb_ack_o = (bus_r == tmr1c_pkg::TMR1C_BUS_ACK);
    wb_dat_o = rdata_r;
    irq      = |(status_r & mask_r);
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence gate_falls_s;
    $fell(gate_in);
  endsequence

  sequence ctrl_wr_s;
    wr_en && wb_sel_i[0] && wb_adr_i == `TMR1C_OFS_CTRL;
  endsequence

  // path checks want ctrl held still, as a write can swap the edge source
  sequence sync_rise_s;
    $rose(ext_raw) && $stable(ctrl_r) && clock_source_select[1] && !ext_clock_sync_ctrl;
  endsequence

  sequence raw_rise_s;
    $rose(ext_raw) && $stable(ctrl_r) && ext_bypass;
  endsequence

  sequence cap_rise_s;
    $rose(cap_sense_osc);
  endsequence

  cap_source_a: assert property (@(posedge clk) disable iff (!reset_n)
    clock_source_select == 2'b11 && counter_run && input_prescale_select == 2'b00
    && cap_tick && !wr_en |=> cnt_r == CNT_W'($past(cnt_r) + 1'b1))
    else $error("cap oscillator tick not counted");
  ext_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
    clock_source_select == 2'b10 && !dedicated_osc_enable && ext_bypass
    && $stable(ctrl_r) && $rose(ext_clock_pin) |-> src_tick)
    else $error("ext pin edge not selected");
  crystal_a: assert property (@(posedge clk) disable iff (!reset_n)
    clock_source_select == 2'b10 && dedicated_osc_enable && ext_bypass
    && $stable(ctrl_r) && $rose(crystal_pins) |-> src_tick)
    else $error("crystal edge not selected");
  // two sync flops then the edge flop: the tick trails the pin by two cycles
  sync_path_a: assert property (@(posedge clk) disable iff (!reset_n)
    sync_rise_s |-> ##2 ext_tick)
    else $error("synchronised edge not two cycles late");
  bypass_path_a: assert property (@(posedge clk) disable iff (!reset_n)
    raw_rise_s |-> ext_tick)
    else $error("raw edge not seen at once");
  cap_sync_a: assert property (@(posedge clk) disable iff (!reset_n)
    cap_rise_s |-> ##2 cap_tick)
    else $error("cap edge lost in synchroniser");
  prescale_one_a: assert property (@(posedge clk) disable iff (!reset_n)
    counter_run && src_tick && input_prescale_select == 2'b00 |-> pre_tick)
    else $error("one to one prescale dropped a tick");
  osc_enable_a: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_wr_s |=> dedicated_osc_enable == $past(wb_dat_i[`TMR1C_OSCEN_BIT]))
    else $error("oscillator enable not written");
  run_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_wr_s |=> counter_run == $past(wb_dat_i[`TMR1C_RUN_BIT]))
    else $error("run bit not written");
  gate_toggle_a: assert property (@(posedge clk) disable iff (!reset_n)
    counter_run && gate_fall |=> gate_ff_r != $past(gate_ff_r))
    else $error("gate flip-flop did not toggle");
  status_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    rd_en && wb_adr_i == `TMR1C_OFS_STATUS && evt == 2'h0 |=> status_r == 2'h0)
    else $error("status not cleared by read");
  ovf_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    ovf_evt |=> status_r[`TMR1C_ST_OVF_BIT])
    else $error("overflow flag not set");
  count_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_en && wb_adr_i == `TMR1C_OFS_COUNT && wb_sel_i == 4'hf
    |=> cnt_r == $past(wb_dat_i[CNT_W-1:0]))
    else $error("count write lost");
  sys_clock_a: assert property (@(posedge clk) disable iff (!reset_n)
    clock_source_select == 2'b01 && counter_run && input_prescale_select == 2'b00
    && !wr_en |=> cnt_r == CNT_W'($past(cnt_r) + 1'b1))
    else $error("system clock source missed a count");
  instr_div_a: assert property (@(posedge clk) disable iff (!reset_n)
    instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick not every fourth cycle");
  sync_ignored_a: assert property (@(posedge clk) disable iff (!reset_n)
    !clock_source_select[1] |-> !ext_bypass)
    else $error("sync bit used for internal source");
  stopped_a: assert property (@(posedge clk) disable iff (!reset_n)
    !counter_run && !wr_en |=> cnt_r == $past(cnt_r))
    else $error("counter moved while stopped");
  gate_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    !counter_run |=> !gate_ff_r)
    else $error("gate flip-flop not cleared");
  bit1_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    !ctrl_r[1])
    else $error("unimplemented bit set");
  gate_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    gate_falls_s |=> status_r[`TMR1C_ST_GATE_BIT])
    else $error("gate event flag not set");
  tick_count_a: assert property (@(posedge clk) disable iff (!reset_n)
    counter_run && pre_tick && !wr_en |=> cnt_r == CNT_W'($past(cnt_r) + 1'b1))
    else $error("counter missed a tick");
endmodule

// ==== tmr1c_timer_tb.sv ====
// tmr1c_timer_tb.sv: self-checking bench for the timer clock and run control block
// assumes the offsets of tmr1c_defines.svh and the single-cycle wishbone timing of the block
`timescale 1ns/1ps
`include "tmr1c_defines.svh"
module tmr1c_timer_tb;
  logic        clk;
  logic        reset_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] got;
  logic        ack;
  logic        ext_pin;
  logic        xtal;
  logic        cap;
  logic        gate;
  logic        osc_en;
  logic [15:0] cnt;
  logic        irq;
  logic [31:0] seed;
  int          num_errors;
  int          checked;
  int          cycles;

  tmr1c_timer #(.CNT_W(16)) tmr1c_timer_i (
    .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_clock_pin(ext_pin), .crystal_pins(xtal), .cap_sense_osc(cap), .gate_in(gate),
    .dedicated_osc_enable(osc_en), .count_value(cnt), .irq(irq)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // generous ceiling, the whole run needs under two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] mk_ctrl(input logic [1:0] src, input logic [1:0] ps,
                                          input logic osc, input logic sy, input logic run);
    return {24'h0, src, ps, osc, sy, 1'b0, run};
  endfunction

  // ticks expected in 96 cycles from an internal source
  function automatic logic [15:0] exp_rate(input logic src0, input logic [1:0] ps);
    return (16'd96 >> ps) / (src0 ? 16'd1 : 16'd4);
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t value got %h exp %h", $time, g, e);
    end
  endtask

  task automatic check_rng(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
    checked++;
    if ((^g === 1'bx) || g < lo || g > hi) begin
      num_errors++;
      $display("CHECK FAILED t=%0t count step %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check_val(got, e);
  endtask

  // rising edges: nx on the pin, nc on the crystal, nk on the cap oscillator
  task automatic pulse(input int nx, input int nc, input int nk);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      ext_pin <= (i < nx);
      xtal    <= (i < nc);
      cap     <= (i < nk);
      repeat (4) @(posedge clk);
      ext_pin <= 1'b0;
      xtal    <= 1'b0;
      cap     <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] r;
    logic [15:0] c0;
    logic [15:0] e;
    reset_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    sel = 4'h0;
    wdat = 32'h0;
    ext_pin = 1'b0;
    xtal = 1'b0;
    cap = 1'b0;
    gate = 1'b1;
    seed = 32'h0945;
    num_errors = 0;
    checked = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(`TMR1C_OFS_CTRL, 32'h0);
    rd_chk(`TMR1C_OFS_COUNT, 32'h0);
    check_val({31'h0, osc_en}, 32'h0);
    check_val({31'h0, irq}, 32'h0);
    $display("test reset done");

    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 32'hff : (rnd() & 32'hfe);
      bus(1'b1, `TMR1C_OFS_CTRL, r);
      rd_chk(`TMR1C_OFS_CTRL, r & 32'hfd);
      check_val({31'h0, osc_en}, {31'h0, r[3]});
    end
    bus(1'b1, `TMR1C_OFS_CTRL, 32'h0);
    check_val({31'h0, osc_en}, 32'h0);
    $display("test control access done");

    // every internal source and prescale code, sync bit random
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      bus(1'b1, `TMR1C_OFS_CTRL, mk_ctrl({1'b0, i[0]}, i[2:1], 1'b0, r[3], 1'b1));
      repeat (8) @(posedge clk);
      c0 = cnt;
      repeat (96) @(posedge clk);
      e = exp_rate(i[0], i[2:1]);
      check_rng(cnt - c0, e - 16'd1, e + 16'd1);
      bus(1'b1, `TMR1C_OFS_CTRL, mk_ctrl({1'b0, i[0]}, i[2:1], 1'b0, r[3], 1'b0));
      repeat (4) @(posedge clk);
      c0 = cnt;
      repeat (20) @(posedge clk);
      check_val({16'h0, cnt}, {16'h0, c0});
    end
    $display("test internal sources done");

    // distinct edge counts per source show which one is counted
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 3; m++) begin
        bus(1'b1, `TMR1C_OFS_CTRL,
            mk_ctrl((m == 2) ? 2'b11 : 2'b10, 2'b00, (m == 1), s[0], 1'b1));
        repeat (8) @(posedge clk);
        c0 = cnt;
        pulse(7, 5, 3);
        repeat (8) @(posedge clk);
        e = (m == 0) ? 16'd7 : (m == 1) ? 16'd5 : 16'd3;
        check_val({16'h0, cnt - c0}, {16'h0, e});
      end
    end
    $display("test external sources done");

    bus(1'b1, `TMR1C_OFS_MASK, 32'h1);
    bus(1'b1, `TMR1C_OFS_CTRL, mk_ctrl(2'b01, 2'b00, 1'b0, 1'b0, 1'b1));
    @(posedge clk);
    gate <= 1'b0;
    repeat (6) @(posedge clk);
    check_val({31'h0, irq}, 32'h1);
    rd_chk(`TMR1C_OFS_GATE, 32'h2);
    rd_chk(`TMR1C_OFS_STATUS, 32'h1);
    check_val({31'h0, irq}, 32'h0);
    rd_chk(`TMR1C_OFS_STATUS, 32'h0);
    bus(1'b1, `TMR1C_OFS_CTRL, mk_ctrl(2'b01, 2'b00, 1'b0, 1'b0, 1'b0));
    rd_chk(`TMR1C_OFS_GATE, 32'h0);
    // masked event while stopped: flag sets, no irq, flip-flop stays clear
    bus(1'b1, `TMR1C_OFS_MASK, 32'h0);
    @(posedge clk);
    gate <= 1'b1;
    repeat (6) @(posedge clk);
    gate <= 1'b0;
    repeat (6) @(posedge clk);
    check_val({31'h0, irq}, 32'h0);
    rd_chk(`TMR1C_OFS_GATE, 32'h0);
    rd_chk(`TMR1C_OFS_STATUS, 32'h1);
    rd_chk(6'h3c, 32'h0);
    $display("test gate event done");

    // count written while stopped holds, then wraps from the system clock
    bus(1'b1, `TMR1C_OFS_COUNT, 32'hfff0);
    repeat (4) @(posedge clk);
    rd_chk(`TMR1C_OFS_COUNT, 32'hfff0);
    bus(1'b1, `TMR1C_OFS_MASK, 32'h2);
    bus(1'b1, `TMR1C_OFS_CTRL, mk_ctrl(2'b01, 2'b00, 1'b0, 1'b0, 1'b1));
    repeat (24) @(posedge clk);
    bus(1'b1, `TMR1C_OFS_CTRL, 32'h0);
    check_val({31'h0, irq}, 32'h1);
    rd_chk(`TMR1C_OFS_STATUS, 32'h2);
    check_val({31'h0, irq}, 32'h0);
    $display("test count overflow done");
    give_verdict();
  end
endmodule
